//--- hdl/sbh_regs.vh
// Purpose: constants shared by the system-instruction executor files
// Assumes: included by bare name from every design file except the sleep controller
// Notes:   offsets are byte addresses on the register slave
`ifndef SBH_REGS_VH
`define SBH_REGS_VH

// ====================================================================
// register offsets and reset values
`define SBH_ADDR_CTRL      4'h0
`define SBH_ADDR_STATE     4'h4
`define SBH_ADDR_IRQ_STAT  4'h8
`define SBH_ADDR_IRQ_MASK  4'hc
`define SBH_CTRL_RESET     2'h0
`define SBH_IRQ_RESET      4'h0

// ====================================================================
// field positions
`define SBH_CTRL_PEND_BIT  0
`define SBH_CTRL_DBG_BIT   1
`define SBH_IRQ_CALL_BIT   0
`define SBH_IRQ_SEND_BIT   1
`define SBH_IRQ_SLEEP_BIT  2
`define SBH_IRQ_WAKE_BIT   3
`define SBH_FLAG_LSB       27

// ====================================================================
// operation codes on the issue port
`define SBH_OP_NOOP  4'h0
`define SBH_OP_DBAR  4'h1
`define SBH_OP_DSYN  4'h2
`define SBH_OP_ISYN  4'h3
`define SBH_OP_RDSR  4'h4
`define SBH_OP_WRSR  4'h5
`define SBH_OP_SEND  4'h6
`define SBH_OP_CALL  4'h7
`define SBH_OP_WEVT  4'h8
`define SBH_OP_WINT  4'h9

// ====================================================================
// special register selectors
`define SBH_SEL_MAINSP   5'h08
`define SBH_SEL_PROCSP   5'h09
`define SBH_SEL_IMASK    5'h10
`define SBH_SEL_BPRI     5'h11
`define SBH_SEL_BPRAISE  5'h12
`define SBH_SEL_FLTMASK  5'h13
`define SBH_SEL_CONTROL  5'h14

`endif

//--- hdl/sbh_spec_regs.v
// Purpose: special register file with privilege filtering
// Assumes: one write per cycle, qualified by the executor
// Notes:   read data is combinational; the executor registers it
`timescale 1ns/1ps
`include "sbh_regs.vh"

module sbh_spec_regs (
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    input  wire        wrEn,
    input  wire        priv,
    input  wire [4:0]  sel,
    input  wire [31:0] wrData,
    input  wire [8:0]  excNum,
    output reg  [31:0] rdData,
    output reg  [4:0]  flags_q,
    output reg  [7:0]  base_priority_mask_q,
    output reg         interrupt_mask_bit_q,
    output reg         fault_mask_bit_q,
    output reg  [1:0]  control_q
);
    reg  [31:0] mainSp_q;
    reg  [31:0] procSp_q;
    wire        statSel = (sel[4:3] == 2'h0);
    wire [7:0]  srcPri = wrData[7:0];
    // raise-only alias: never lowers priority, zero source is ignored
    wire        raiseOk = (srcPri != 8'h00) &&
                          ((base_priority_mask_q == 8'h00) || (srcPri < base_priority_mask_q));

    // ====================================================================
    // write path
    always @(posedge clk) begin
        if (srst) begin
            flags_q     <= 5'h00;
            base_priority_mask_q   <= 8'h00;
            interrupt_mask_bit_q   <= 1'b0;
            fault_mask_bit_q <= 1'b0;
            control_q   <= 2'h0;
            mainSp_q    <= 32'h00000000;
            procSp_q    <= 32'h00000000;
        end else if (ce && wrEn) begin
            // status group: only the flag field is writable, exception and
            // execution-state bits are read-only here in every mode
            if (statSel && !sel[2])
                flags_q <= wrData[31:`SBH_FLAG_LSB];
            if (priv) begin
                case (sel)
                    `SBH_SEL_MAINSP:  mainSp_q    <= {wrData[31:2], 2'h0};
                    `SBH_SEL_PROCSP:  procSp_q    <= {wrData[31:2], 2'h0};
                    `SBH_SEL_IMASK:   interrupt_mask_bit_q   <= wrData[0];
                    `SBH_SEL_BPRI:    base_priority_mask_q   <= srcPri;
                    `SBH_SEL_BPRAISE: if (raiseOk) base_priority_mask_q <= srcPri;
                    `SBH_SEL_FLTMASK: fault_mask_bit_q <= wrData[0];
                    `SBH_SEL_CONTROL: control_q   <= wrData[1:0];
                    default: ;
                endcase
            end
        end
    end

    // ====================================================================
    // read path
    always @* begin
        rdData = 32'h00000000;
        if (statSel) begin
            if (!sel[2])
                rdData[31:`SBH_FLAG_LSB] = flags_q;
            if (sel[0])
                rdData[8:0] = excNum;
        end else begin
            case (sel)
                `SBH_SEL_MAINSP:  rdData = mainSp_q;
                `SBH_SEL_PROCSP:  rdData = procSp_q;
                `SBH_SEL_IMASK:   rdData[0] = interrupt_mask_bit_q;
                `SBH_SEL_BPRI,
                `SBH_SEL_BPRAISE: rdData[7:0] = base_priority_mask_q;
                `SBH_SEL_FLTMASK: rdData[0] = fault_mask_bit_q;
                `SBH_SEL_CONTROL: rdData[1:0] = control_q;
                default:          rdData = 32'h00000000;
            endcase
        end
    end
endmodule // sbh_spec_regs

//--- hdl/sbh_sleep_ctl.v
// Purpose: event register and sleep/wake tracking for the two hints
// Assumes: enterWevt only when the event register is clear
// Notes:   wake_q is a one-cycle pulse that ends the sleep
`timescale 1ns/1ps

module sbh_sleep_ctl (
    input  wire clk,
    input  wire srst,
    input  wire ce,
    input  wire enterWevt,
    input  wire enterWint,
    input  wire consume,
    input  wire sendLocal,
    input  wire extEvent,
    input  wire pendNew,
    input  wire eventOnPend,
    input  wire excWake,
    input  wire dbgReq,
    input  wire dbgEn,
    output reg  eventReg_q,
    output reg  sleeping_q,
    output reg  wake_q
);
    reg  wintMode_q;
    wire pendEvt = pendNew && eventOnPend;
    wire wakeWevt = excWake || pendEvt || (dbgReq && dbgEn) || extEvent;
    wire wakeWint = excWake || dbgReq;
    wire wakeNow = sleeping_q && (wintMode_q ? wakeWint : wakeWevt);

    always @(posedge clk) begin
        if (srst) begin
            eventReg_q <= 1'b0;
            sleeping_q <= 1'b0;
            wintMode_q <= 1'b0;
            wake_q     <= 1'b0;
        end else if (ce) begin
            // a new event beats the clear done by the hint
            if (sendLocal || extEvent || pendEvt)
                eventReg_q <= 1'b1;
            else if (consume)
                eventReg_q <= 1'b0;
            wake_q <= wakeNow;
            if (wakeNow)
                sleeping_q <= 1'b0;
            else if (enterWevt || enterWint) begin
                sleeping_q <= 1'b1;
                wintMode_q <= enterWint;
            end
        end
    end
endmodule // sbh_sleep_ctl

//--- hdl/sbh_exec.v
// Purpose: executes barrier, special-move, event, call and sleep hints
// Assumes: issue port and status inputs are synchronous to clk
// Notes:   register slave is Avalon-MM with waitrequest, 4-bit byte address
//
// How it works
// - data barrier holds later memory accesses until earlier ones finish
// - sync barrier stalls every later instruction until memory is idle
// - instruction barrier flushes pipeline so later instructions refetch
// - reading the raise alias returns the base priority mask
// - unprivileged special writes reach only the application flags
// - unprivileged status writes ignore unallocated and execution bits
// - raise alias writes only nonzero values below current or when zero
// - status writes load condition flags straight from source bits
// - no-operation changes nothing and may take no cycle
// - send-event pulses event output and sets local event register
// - supervisor call raises its exception; immediate is ignored
// - wait-event with clear register sleeps until a wake source
// - wait-event with set register clears it and continues
// - wait-interrupt sleeps until exception or any debug request
// - only the special write ever alters condition flags
// - every instruction here executes only when its condition passes
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sbh_regs.vh"

module sbh_exec (
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    input  wire        issueValid,
    input  wire [3:0]  issueOp,
    input  wire        issueCondPass,
    input  wire [4:0]  issueSpecSel,
    input  wire [31:0] issueSrc,
    input  wire        privileged,
    input  wire [8:0]  excNum,
    input  wire        memIdle,
    input  wire        excWake,
    input  wire        pendNew,
    input  wire        dbgReq,
    input  wire        extEvent,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         issueReady,
    output reg         opDone,
    output reg         rdValid,
    output reg  [31:0] rdData,
    output reg         memHold,
    output reg         flushPipe,
    output reg         eventOut,
    output reg         callReq,
    output wire        sleeping,
    output wire [4:0]  flags,
    output wire [7:0]  base_priority_mask,
    output wire        interrupt_mask_bit,
    output wire        fault_mask_bit,
    output wire [1:0]  controlBits,
    output reg         irq
);
    // ====================================================================
    // state machine
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_DRAIN = 4'b0010;
    localparam [3:0] ST_FLUSH = 4'b0100;
    localparam [3:0] ST_SLEEP = 4'b1000;

    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [1:0]  ctrl_q;
    reg  [3:0]  irqStat_q;
    reg  [3:0]  irqMask_q;
    reg  [3:0]  irqSet;

    wire        eventReg;
    wire        wakeP;
    wire [31:0] sregRd;

    // an op takes effect only when accepted and its condition holds
    wire accept = issueValid && issueReady && (state_q == ST_IDLE);
    wire exec   = accept && issueCondPass;
    wire isOp0  = exec && (issueOp == `SBH_OP_DBAR);
    wire isDsyn = exec && (issueOp == `SBH_OP_DSYN);
    wire isIsyn = exec && (issueOp == `SBH_OP_ISYN);
    wire isRdsr = exec && (issueOp == `SBH_OP_RDSR);
    wire isWrsr = exec && (issueOp == `SBH_OP_WRSR);
    wire isSend = exec && (issueOp == `SBH_OP_SEND);
    wire isCall = exec && (issueOp == `SBH_OP_CALL);
    wire isWevt = exec && (issueOp == `SBH_OP_WEVT);
    wire isWint = exec && (issueOp == `SBH_OP_WINT);
    wire wevtGo = isWevt && eventReg;
    wire wevtZz = isWevt && !eventReg;

    wire busReq   = avs_read || avs_write;
    wire busTake  = busReq && !avs_waitrequest;
    wire regWrite = busTake && avs_write;

    // ====================================================================
    // submodules
    // flags only move on an accepted special write; the other ops never
    // drive the write enable, so flags hold through them
    sbh_spec_regs u_sregs (
        .clk         (clk),
        .srst        (srst),
        .ce          (ce),
        .wrEn        (isWrsr),
        .priv        (privileged),
        .sel         (issueSpecSel),
        .wrData      (issueSrc),
        .excNum      (excNum),
        .rdData      (sregRd),
        .flags_q     (flags),
        .base_priority_mask_q   (base_priority_mask),
        .interrupt_mask_bit_q   (interrupt_mask_bit),
        .fault_mask_bit_q (fault_mask_bit),
        .control_q   (controlBits)
    );

    sbh_sleep_ctl u_sleep (
        .clk         (clk),
        .srst        (srst),
        .ce          (ce),
        .enterWevt   (wevtZz),
        .enterWint   (isWint),
        .consume     (wevtGo),
        .sendLocal   (isSend),
        .extEvent    (extEvent),
        .pendNew     (pendNew),
        .eventOnPend (ctrl_q[`SBH_CTRL_PEND_BIT]),
        .excWake     (excWake),
        .dbgReq      (dbgReq),
        .dbgEn       (ctrl_q[`SBH_CTRL_DBG_BIT]),
        .eventReg_q  (eventReg),
        .sleeping_q  (sleeping),
        .wake_q      (wakeP)
    );

    // ====================================================================
    // next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (isDsyn && !memIdle)
                    state_d = ST_DRAIN;
                else if (isIsyn)
                    state_d = ST_FLUSH;
                else if (wevtZz || isWint)
                    state_d = ST_SLEEP;
            end
            ST_DRAIN: begin
                if (memIdle)
                    state_d = ST_IDLE;
            end
            ST_FLUSH: state_d = ST_IDLE;
            ST_SLEEP: begin
                if (wakeP)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // ====================================================================
    // execution outputs
    always @(posedge clk) begin
        if (srst) begin
            state_q    <= ST_IDLE;
            issueReady <= 1'b0;
            opDone     <= 1'b0;
            rdValid    <= 1'b0;
            rdData     <= 32'h00000000;
            memHold    <= 1'b0;
            flushPipe  <= 1'b0;
            eventOut   <= 1'b0;
            callReq    <= 1'b0;
        end else if (ce) begin
            state_q    <= state_d;
            issueReady <= (state_d == ST_IDLE);
            rdValid    <= isRdsr;
            if (isRdsr)
                rdData <= sregRd;
            // a no-op completes here with nothing else touched
            opDone <= (accept && !(isDsyn && !memIdle) && !isIsyn &&
                       !wevtZz && !isWint) ||
                      (state_q == ST_DRAIN && memIdle) ||
                      (state_q == ST_FLUSH) ||
                      (state_q == ST_SLEEP && wakeP);
            // non-memory ops keep flowing; only memory traffic waits
            if (isOp0 && !memIdle)
                memHold <= 1'b1;
            else if (memIdle)
                memHold <= 1'b0;
            flushPipe <= isIsyn;
            eventOut  <= isSend;
            // the immediate is not an input: the handler reads it back
            callReq   <= isCall;
        end
    end

    // ====================================================================
    // interrupt events
    always @* begin
        irqSet = 4'h0;
        irqSet[`SBH_IRQ_CALL_BIT]  = isCall;
        irqSet[`SBH_IRQ_SEND_BIT]  = isSend;
        irqSet[`SBH_IRQ_SLEEP_BIT] = wevtZz || isWint;
        irqSet[`SBH_IRQ_WAKE_BIT]  = wakeP;
    end

    // ====================================================================
    // register slave: one wait cycle, then a one-cycle answer
    always @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            ctrl_q          <= `SBH_CTRL_RESET;
            irqStat_q       <= `SBH_IRQ_RESET;
            irqMask_q       <= `SBH_IRQ_RESET;
            irq             <= 1'b0;
        end else if (ce) begin
            avs_waitrequest <= !(busReq && avs_waitrequest);
            if (busReq && avs_waitrequest && avs_read) begin
                case (avs_address)
                    `SBH_ADDR_CTRL:
                        avs_readdata <= {30'h0, ctrl_q};
                    `SBH_ADDR_STATE:
                        avs_readdata <= {16'h0, base_priority_mask, 4'h0,
                                         fault_mask_bit, interrupt_mask_bit, sleeping, eventReg};
                    `SBH_ADDR_IRQ_STAT:
                        avs_readdata <= {28'h0, irqStat_q};
                    `SBH_ADDR_IRQ_MASK:
                        avs_readdata <= {28'h0, irqMask_q};
                    default:
                        avs_readdata <= 32'h00000000;
                endcase
            end
            if (regWrite && avs_byteenable[0] && avs_address == `SBH_ADDR_CTRL)
                ctrl_q <= avs_writedata[1:0];
            if (regWrite && avs_byteenable[0] && avs_address == `SBH_ADDR_IRQ_MASK)
                irqMask_q <= avs_writedata[3:0];
            // a new event outranks a write-one-to-clear in the same cycle
            if (regWrite && avs_byteenable[0] && avs_address == `SBH_ADDR_IRQ_STAT)
                irqStat_q <= (irqStat_q & ~avs_writedata[3:0]) | irqSet;
            else
                irqStat_q <= irqStat_q | irqSet;
            irq <= |(irqStat_q & irqMask_q);
        end
    end
endmodule // sbh_exec

//--- tb/sbh_exec_properties.sv
// Purpose: port assertions for the system-instruction executor
// Assumes: bound to sbh_exec; ce stays high while checked
// Notes:   an op is taken when ce, valid and ready meet at an edge
`timescale 1ns/1ps
`include "sbh_regs.vh"

module sbh_exec_properties (
    input wire        clk,
    input wire        srst,
    input wire        ce,
    input wire        issueValid,
    input wire [3:0]  issueOp,
    input wire        issueCondPass,
    input wire [4:0]  issueSpecSel,
    input wire [31:0] issueSrc,
    input wire        privileged,
    input wire        memIdle,
    input wire        issueReady,
    input wire        opDone,
    input wire        rdValid,
    input wire [31:0] rdData,
    input wire        memHold,
    input wire        flushPipe,
    input wire        eventOut,
    input wire        callReq,
    input wire [4:0]  flags,
    input wire [7:0]  base_priority_mask
);
    // ====================
    // decode of the op taken at this edge
    wire       take  = ce && issueValid && issueReady;
    wire       run   = take && issueCondPass;
    wire [7:0] srcLo = issueSrc[7:0];
    wire       raise = run && issueOp == `SBH_OP_WRSR && privileged
                       && issueSpecSel == `SBH_SEL_BPRAISE;
    wire       lower = srcLo != 8'h00 && (base_priority_mask == 8'h00 || srcLo < base_priority_mask);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_ev_pulse;
        ##1 (eventOut && opDone) ##1 !eventOut;
    endsequence
    sequence s_stall;
        ##1 (!issueReady && !opDone);
    endsequence

    // ====================
    // properties
    a_send_pulse: assert property (
        run && issueOp == `SBH_OP_SEND |-> s_ev_pulse) else $error("send event pulse bad");
    a_sync_stall: assert property (
        run && issueOp == `SBH_OP_DSYN && !memIdle |-> s_stall) else $error("barrier ran on");
    a_barrier_hold: assert property (
        run && issueOp == `SBH_OP_DBAR && !memIdle |=> memHold) else $error("no memory hold");
    a_pipe_flush: assert property (
        run && issueOp == `SBH_OP_ISYN |-> ##[1:2] flushPipe) else $error("no pipeline flush");
    a_call_raise: assert property (
        run && issueOp == `SBH_OP_CALL |=> callReq) else $error("no call request");
    a_alias_read: assert property (
        run && issueOp == `SBH_OP_RDSR && issueSpecSel == `SBH_SEL_BPRAISE
        |=> rdValid && rdData == {24'h0, $past(base_priority_mask)}) else $error("alias read bad");
    a_flag_load: assert property (
        run && issueOp == `SBH_OP_WRSR && issueSpecSel == 5'h00
        |=> flags == 5'($past(issueSrc) >> 27)) else $error("flags not loaded");
    a_flags_kept: assert property (
        take && issueOp != `SBH_OP_WRSR |=> $stable(flags)) else $error("flags changed");
    a_raise_write: assert property (
        raise && lower |=> base_priority_mask == $past(srcLo)) else $error("raise not applied");
    a_raise_keep: assert property (
        raise && !lower |=> $stable(base_priority_mask)) else $error("raise wrongly applied");
    a_cond_skip: assert property (
        take && !issueCondPass |=> !(eventOut || callReq || flushPipe || rdValid))
        else $error("failed condition had effect");
endmodule // sbh_exec_properties

bind sbh_exec sbh_exec_properties u_props (.clk, .srst, .ce, .issueValid, .issueOp,
    .issueCondPass, .issueSpecSel, .issueSrc, .privileged, .memIdle, .issueReady, .opDone,
    .rdValid, .rdData, .memHold, .flushPipe, .eventOut, .callReq, .flags, .base_priority_mask);

//--- tb/sbh_far_model.sv
// Purpose: far side model: memory system busy window and an event peer
// Assumes: bench commands busy windows and peer sends
// Notes:   peer event lands one cycle after the send request
`timescale 1ns/1ps

module sbh_far_model (
    input  wire       clk,
    input  wire       srst,
    input  wire       busyGo,
    input  wire [3:0] busyLen,
    input  wire       peerSend,
    input  wire       eventOut,
    output wire       memIdle,
    output reg        extEvent_q,
    output reg  [3:0] evSeen_q
);
    reg [3:0] busy_q;

    // ====================
    // idle only once the busy window has drained
    assign memIdle = busy_q == 4'h0 && !busyGo;

    always @(posedge clk) begin
        if (srst) begin
            busy_q     <= 4'h0;
            extEvent_q <= 1'b0;
            evSeen_q   <= 4'h0;
        end else begin
            busy_q     <= busyGo ? busyLen : busy_q - {3'h0, busy_q != 4'h0};
            extEvent_q <= peerSend;
            evSeen_q   <= evSeen_q + {3'h0, eventOut};
        end
    end
endmodule // sbh_far_model

//--- tb/sbh_exec_tb.sv
// Purpose: directed test of the system-instruction executor
// Assumes: ce held high; far model supplies memory idle and peer events
// Notes:   outputs are read 1 ns after an edge so its updates have landed
`timescale 1ns/1ps
`include "sbh_regs.vh"

module sbh_exec_tb;
    reg         clk = 1'b0;
    reg         srst = 1'b1;
    reg         issueValid = 1'b0;
    reg  [3:0]  issueOp = 4'h0;
    reg         issueCondPass = 1'b0;
    reg  [4:0]  issueSpecSel = 5'h00;
    reg  [31:0] issueSrc = 32'h0;
    reg         privileged = 1'b0;
    reg         dbgReq = 1'b0;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg         busyGo = 1'b0;
    reg  [3:0]  busyLen = 4'h0;
    reg         peerSend = 1'b0;
    wire [31:0] avs_readdata, rdData;
    wire [4:0]  flags;
    wire [7:0]  base_priority_mask;
    wire [3:0]  evSeen;
    wire [1:0]  ctl;
    wire        avs_waitrequest, issueReady, opDone, rdValid, memHold, flushPipe;
    wire        eventOut, callReq, sleeping, irq, memIdle, extEvent;
    integer     fails = 0;
    integer     num_checks = 0;
    integer     i;
    reg  [31:0] q, rdSeen;
    reg  [3:0]  saw;

    always #5 clk = ~clk;

    sbh_exec dut (.clk, .srst, .ce(1'b1), .issueValid, .issueOp, .issueCondPass,
        .issueSpecSel, .issueSrc, .privileged, .excNum(9'h000), .memIdle, .excWake(1'b0),
        .pendNew(1'b0), .dbgReq, .extEvent, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .issueReady,
        .opDone, .rdValid, .rdData, .memHold, .flushPipe, .eventOut, .callReq, .sleeping,
        .flags, .base_priority_mask, .interrupt_mask_bit(), .fault_mask_bit(), .controlBits(ctl), .irq);
    sbh_far_model far (.clk, .srst, .busyGo, .busyLen, .peerSend, .eventOut, .memIdle,
        .extEvent_q(extEvent), .evSeen_q(evSeen));

    // ====================
    // checking and closing
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            if (fails == 0 && num_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task hang;
        begin
            fails = fails + 1;
            finish_test;
        end
    endtask

    // ====================
    // bus and issue port access
    task bus(input wr, input [3:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= !wr;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (avs_waitrequest !== 1'b0 && n < 40);
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            if (n >= 40) hang;
        end
    endtask
    // gathers output pulses until the op completes
    task collect;
        integer n;
        begin
            saw = 4'h0;
            for (n = 0; n < 60; n = n + 1) begin
                #1;
                saw = saw | {rdValid, flushPipe, callReq, eventOut};
                if (rdValid === 1'b1) rdSeen = rdData;
                if (opDone === 1'b1) n = 99;
                else @(posedge clk);
            end
            if (n == 60) hang;
        end
    endtask
    task issue(input [3:0] op, input [4:0] sel, input [31:0] src, input cnd, input prv,
        input w);
        integer n;
        begin
            @(posedge clk);
            issueValid <= 1'b1;
            issueOp <= op;
            issueSpecSel <= sel;
            issueSrc <= src;
            issueCondPass <= cnd;
            privileged <= prv;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (issueReady !== 1'b1 && n < 40);
            issueValid <= 1'b0;
            if (n >= 40) hang;
            if (w) collect;
        end
    endtask
    task strobe(input dbg);
        begin
            @(posedge clk);
            dbgReq <= dbg;
            peerSend <= !dbg;
            @(posedge clk);
            dbgReq <= 1'b0;
            peerSend <= 1'b0;
        end
    endtask
    task busy;
        begin
            @(posedge clk);
            busyGo <= 1'b1;
            busyLen <= 4'h6;
            @(posedge clk);
            busyGo <= 1'b0;
        end
    endtask

    // ====================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1 chk({avs_waitrequest, base_priority_mask, flags}, 32'h2000);
        issue(`SBH_OP_SEND, 5'h00, 0, 0, 1, 1);
        chk(saw, 4'h0);
        issue(`SBH_OP_SEND, 5'h00, 0, 1, 1, 1);
        chk(saw, 4'h1);
        chk(irq, 0);
        bus(0, `SBH_ADDR_STATE, 0);
        chk(q[0], 1);
        chk(evSeen, 1);
        bus(1, `SBH_ADDR_IRQ_MASK, 32'h2);
        // the level output follows status and mask one edge late
        @(posedge clk);
        #1 chk(irq, 1);
        bus(1, `SBH_ADDR_IRQ_STAT, 32'h2);
        repeat (2) @(posedge clk);
        #1 chk(irq, 0);
        bus(0, 4'h2, 0);
        chk(q, 0);
        issue(`SBH_OP_WEVT, 5'h00, 0, 1, 1, 1);
        chk(sleeping, 0);
        bus(0, `SBH_ADDR_STATE, 0);
        chk(q[0], 0);
        issue(`SBH_OP_WEVT, 5'h00, 0, 1, 1, 0);
        repeat (3) @(posedge clk);
        #1 chk(sleeping, 1);
        strobe(0);
        collect;
        chk(sleeping, 0);
        // a peer event must not end a wait for interrupt
        issue(`SBH_OP_WINT, 5'h00, 0, 1, 1, 0);
        strobe(0);
        repeat (3) @(posedge clk);
        #1 chk(sleeping, 1);
        strobe(1);
        collect;
        chk(sleeping, 0);
        issue(`SBH_OP_WRSR, 5'h03, 32'ha90001ff, 1, 0, 1);
        chk(flags, 5'h15);
        issue(`SBH_OP_RDSR, 5'h03, 0, 1, 1, 1);
        chk(rdSeen, 32'ha8000000);
        issue(`SBH_OP_WRSR, `SBH_SEL_BPRI, 0, 1, 1, 1);
        for (i = 0; i < 4; i = i + 1) begin
            issue(`SBH_OP_WRSR, `SBH_SEL_BPRAISE, (32'h10006050 >> (8 * i)) & 32'hff, 1, 1, 1);
            chk(base_priority_mask, (32'h10505050 >> (8 * i)) & 32'hff);
        end
        issue(`SBH_OP_WRSR, `SBH_SEL_BPRI, 32'h1, 1, 0, 1);
        chk(base_priority_mask, 8'h10);
        issue(`SBH_OP_RDSR, `SBH_SEL_BPRAISE, 0, 1, 1, 1);
        chk({saw, rdSeen}, 36'h800000010);
        issue(`SBH_OP_RDSR, `SBH_SEL_BPRAISE, 0, 0, 1, 1);
        chk(saw, 4'h0);
        issue(`SBH_OP_NOOP, 5'h00, 32'hffffffff, 1, 1, 1);
        chk({saw, flags}, 9'h015);
        issue(`SBH_OP_ISYN, 5'h00, 0, 1, 1, 1);
        chk(saw[2], 1);
        for (i = 0; i < 2; i = i + 1) begin
            issue(`SBH_OP_CALL, 5'h00, i * 255, 1, 1, 1);
            chk(saw, 4'h2);
        end
        chk(flags, 5'h15);
        busy;
        issue(`SBH_OP_DSYN, 5'h00, 0, 1, 1, 0);
        #1 chk(issueReady, 0);
        collect;
        chk(memIdle, 1);
        busy;
        issue(`SBH_OP_DBAR, 5'h00, 0, 1, 1, 1);
        chk({memIdle, memHold}, 2'h1);
        repeat (10) @(posedge clk);
        #1 chk(memHold, 0);
        issue(`SBH_OP_WRSR, `SBH_SEL_CONTROL, 32'h3, 1, 1, 1);
        chk(ctl, 2'h3);
        issue(`SBH_OP_WRSR, `SBH_SEL_IMASK, 32'h1, 1, 1, 1);
        issue(`SBH_OP_WRSR, `SBH_SEL_FLTMASK, 32'h1, 1, 1, 1);
        bus(0, `SBH_ADDR_STATE, 0);
        chk(q[3:2], 2'h3);
        bus(1, `SBH_ADDR_CTRL, 32'h3);
        bus(0, `SBH_ADDR_CTRL, 0);
        chk(q, 32'h3);
        finish_test;
    end
endmodule // sbh_exec_tb
